// File: hdl/bstc_pkg.sv
package bstc_pkg;
  localparam int IR_W  = 8;
  localparam int BND_W = 88;
  localparam int CTL_W = 23;
  localparam int ID_W  = 32;
  localparam logic [IR_W-1:0]  IR_CAPTURE = 8'h81;
  localparam logic [IR_W-1:0]  IR_RESET   = 8'h81;
  localparam logic [IR_W-1:0]  OP_IDCODE  = 8'h81;
  localparam logic [IR_W-1:0]  OP_EXTEST  = 8'h00;
  localparam logic [IR_W-1:0]  OP_SAMPLE  = 8'h82;
  localparam logic [IR_W-1:0]  OP_RUNT    = 8'h09;
  localparam logic [BND_W-1:0] BND_RESET  = 88'hc0_0000_0000_0000_0000_0000;
  localparam logic [CTL_W-1:0] CTL_RESET  = 23'h000000;
  // Arbitrary identification value
  localparam logic [ID_W-1:0]  IDCODE_DEF = 32'h0a0b_c001;

  typedef enum logic [3:0] {
    ST_TLR    = 4'h0,
    ST_RTI    = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR  = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PAU_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } bstc_state_t;

  typedef enum logic [1:0] {
    SEL_BYP = 2'h0,
    SEL_ID  = 2'h1,
    SEL_BND = 2'h2,
    SEL_CTL = 2'h3
  } bstc_sel_t;

  typedef struct packed {
    logic             rst_s1;
    logic             rst_s2;
    logic             ce_s1;
    logic             ce_s2;
    bstc_state_t      state;
    logic [IR_W-1:0]  ir_sh;
    logic [BND_W-1:0] bnd_sh;
    logic [CTL_W-1:0] ctl_sh;
    logic             byp_sh;
    logic [ID_W-1:0]  id_sh;
    logic [BND_W-1:0] pin_s1;
    logic [BND_W-1:0] pin_s2;
    logic             run_lvl;
    logic             mode_lvl;
  } bstc_rise_t;

  typedef struct packed {
    logic             tdo;
    logic             tdo_oe;
    logic [IR_W-1:0]  ir_cur;
    logic [BND_W-1:0] bnd_upd;
    logic [CTL_W-1:0] ctl_upd;
  } bstc_fall_t;

  typedef struct packed {
    logic run_s1;
    logic run_s2;
    logic mode_s1;
    logic mode_s2;
  } bstc_core_t;
endpackage

// File: hdl/bstc_top.sv
`timescale 1ns/1ps
`default_nettype none
module bstc_top #(
  parameter logic [bstc_pkg::ID_W-1:0] IDCODE_VAL = bstc_pkg::IDCODE_DEF
) (
  input  wire logic                       CORE_CLK_IN,
  input  wire logic                       RST_IN,
  input  wire logic                       CE_IN,
  input  wire logic                       TCK_IN,
  input  wire logic                       TMS_IN,
  input  wire logic                       TDI_IN,
  input  wire logic [bstc_pkg::BND_W-1:0] BOUNDARY_SAMPLE_IN,
  output var  logic                       TDO_OUT,
  output var  logic                       TDO_OE_OUT,
  output var  logic [bstc_pkg::BND_W-1:0] BOUNDARY_DRIVE_OUT,
  output var  logic [bstc_pkg::CTL_W-1:0] CONTROL_CHAIN_OUT,
  output var  logic                       TEST_MODE_OUT,
  output var  logic                       RUN_TEST_OUT
);
  bstc_pkg::bstc_rise_t p_reg;
  bstc_pkg::bstc_rise_t p_next;
  bstc_pkg::bstc_fall_t n_reg;
  bstc_pkg::bstc_fall_t n_next;
  bstc_pkg::bstc_core_t c_reg;
  bstc_pkg::bstc_core_t c_next;
  bstc_pkg::bstc_sel_t  sel;
  logic                 ce_t;
  logic                 rst_t;
  logic                 dr_lsb;

  assign ce_t  = p_reg.ce_s2;
  assign rst_t = p_reg.rst_s2;

  // Chain selection from current instruction
  always_comb
  begin
    sel = bstc_pkg::SEL_BYP;
    if (^n_reg.ir_cur == 1'b0)
    begin
      case (n_reg.ir_cur)
        bstc_pkg::OP_IDCODE: sel = bstc_pkg::SEL_ID;
        bstc_pkg::OP_EXTEST: sel = bstc_pkg::SEL_BND;
        bstc_pkg::OP_SAMPLE: sel = bstc_pkg::SEL_BND;
        bstc_pkg::OP_RUNT:   sel = bstc_pkg::SEL_CTL;
        default:             sel = bstc_pkg::SEL_BYP;
      endcase
    end
  end

  // Lsb of the one chain in the scan path
  always_comb
  begin
    case (sel)
      bstc_pkg::SEL_ID:  dr_lsb = p_reg.id_sh[0];
      bstc_pkg::SEL_BND: dr_lsb = p_reg.bnd_sh[0];
      bstc_pkg::SEL_CTL: dr_lsb = p_reg.ctl_sh[0];
      default:           dr_lsb = p_reg.byp_sh;
    endcase
  end

  // Rising test clock domain
  always_comb
  begin
    p_next = p_reg;
    p_next.rst_s1 = RST_IN;
    p_next.rst_s2 = p_reg.rst_s1;
    p_next.ce_s1 = CE_IN;
    p_next.ce_s2 = p_reg.ce_s1;
    p_next.pin_s1 = BOUNDARY_SAMPLE_IN;
    p_next.pin_s2 = p_reg.pin_s1;
    if (rst_t)
    begin
      p_next.state = bstc_pkg::ST_TLR;
      p_next.run_lvl = 1'b0;
      p_next.mode_lvl = 1'b0;
    end
    else if (ce_t)
    begin
      case (p_reg.state)
        bstc_pkg::ST_TLR:
          p_next.state = TMS_IN ? bstc_pkg::ST_TLR : bstc_pkg::ST_RTI;
        bstc_pkg::ST_RTI:
          p_next.state = TMS_IN ? bstc_pkg::ST_SEL_DR : bstc_pkg::ST_RTI;
        bstc_pkg::ST_SEL_DR:
          p_next.state = TMS_IN ? bstc_pkg::ST_SEL_IR : bstc_pkg::ST_CAP_DR;
        bstc_pkg::ST_CAP_DR:
          p_next.state = TMS_IN ? bstc_pkg::ST_EX1_DR : bstc_pkg::ST_SH_DR;
        bstc_pkg::ST_SH_DR:
          p_next.state = TMS_IN ? bstc_pkg::ST_EX1_DR : bstc_pkg::ST_SH_DR;
        bstc_pkg::ST_EX1_DR:
          p_next.state = TMS_IN ? bstc_pkg::ST_UPD_DR : bstc_pkg::ST_PAU_DR;
        bstc_pkg::ST_PAU_DR:
          p_next.state = TMS_IN ? bstc_pkg::ST_EX2_DR : bstc_pkg::ST_PAU_DR;
        bstc_pkg::ST_EX2_DR:
          p_next.state = TMS_IN ? bstc_pkg::ST_UPD_DR : bstc_pkg::ST_SH_DR;
        bstc_pkg::ST_UPD_DR:
          p_next.state = TMS_IN ? bstc_pkg::ST_SEL_DR : bstc_pkg::ST_RTI;
        bstc_pkg::ST_SEL_IR:
          p_next.state = TMS_IN ? bstc_pkg::ST_TLR : bstc_pkg::ST_CAP_IR;
        bstc_pkg::ST_CAP_IR:
          p_next.state = TMS_IN ? bstc_pkg::ST_EX1_IR : bstc_pkg::ST_SH_IR;
        bstc_pkg::ST_SH_IR:
          p_next.state = TMS_IN ? bstc_pkg::ST_EX1_IR : bstc_pkg::ST_SH_IR;
        bstc_pkg::ST_EX1_IR:
          p_next.state = TMS_IN ? bstc_pkg::ST_UPD_IR : bstc_pkg::ST_PAU_IR;
        bstc_pkg::ST_PAU_IR:
          p_next.state = TMS_IN ? bstc_pkg::ST_EX2_IR : bstc_pkg::ST_PAU_IR;
        bstc_pkg::ST_EX2_IR:
          p_next.state = TMS_IN ? bstc_pkg::ST_UPD_IR : bstc_pkg::ST_SH_IR;
        bstc_pkg::ST_UPD_IR:
          p_next.state = TMS_IN ? bstc_pkg::ST_SEL_DR : bstc_pkg::ST_RTI;
        default:
          p_next.state = bstc_pkg::ST_TLR;
      endcase
      case (p_reg.state)
        bstc_pkg::ST_TLR:
        begin
          p_next.bnd_sh = bstc_pkg::BND_RESET;
          p_next.ctl_sh = bstc_pkg::CTL_RESET;
        end
        bstc_pkg::ST_CAP_DR:
        begin
          case (sel)
            bstc_pkg::SEL_ID:  p_next.id_sh = IDCODE_VAL;
            bstc_pkg::SEL_BND: p_next.bnd_sh = p_reg.pin_s2;
            bstc_pkg::SEL_CTL: p_next.ctl_sh = p_reg.ctl_sh;
            default:           p_next.byp_sh = 1'b0;
          endcase
        end
        bstc_pkg::ST_SH_DR:
        begin
          case (sel)
            bstc_pkg::SEL_ID:
              p_next.id_sh = {TDI_IN, p_reg.id_sh[bstc_pkg::ID_W-1:1]};
            bstc_pkg::SEL_BND:
              p_next.bnd_sh = {TDI_IN, p_reg.bnd_sh[bstc_pkg::BND_W-1:1]};
            bstc_pkg::SEL_CTL:
              p_next.ctl_sh = {TDI_IN, p_reg.ctl_sh[bstc_pkg::CTL_W-1:1]};
            default:
              p_next.byp_sh = TDI_IN;
          endcase
        end
        bstc_pkg::ST_CAP_IR:
          p_next.ir_sh = bstc_pkg::IR_CAPTURE;
        bstc_pkg::ST_SH_IR:
          p_next.ir_sh = {TDI_IN, p_reg.ir_sh[bstc_pkg::IR_W-1:1]};
        default:
          p_next.ir_sh = p_reg.ir_sh;
      endcase
      // Test operations only while idle
      p_next.run_lvl = (p_next.state == bstc_pkg::ST_RTI) && (sel == bstc_pkg::SEL_CTL);
      // Test mode drops on the edge that enters the reset state
      p_next.mode_lvl = (p_next.state != bstc_pkg::ST_TLR) &&
                        (n_reg.ir_cur == bstc_pkg::OP_EXTEST);
    end
  end

  always_ff @(posedge TCK_IN)
  begin
    p_reg <= p_next;
  end

  // Falling test clock domain
  always_comb
  begin
    n_next = n_reg;
    if (ce_t)
    begin
      n_next.tdo_oe = (p_reg.state == bstc_pkg::ST_SH_DR) ||
                      (p_reg.state == bstc_pkg::ST_SH_IR);
      n_next.tdo = (p_reg.state == bstc_pkg::ST_SH_IR) ? p_reg.ir_sh[0] : dr_lsb;
      case (p_reg.state)
        bstc_pkg::ST_TLR:
        begin
          n_next.ir_cur = bstc_pkg::IR_RESET;
          n_next.bnd_upd = bstc_pkg::BND_RESET;
          n_next.ctl_upd = bstc_pkg::CTL_RESET;
        end
        bstc_pkg::ST_UPD_IR:
          n_next.ir_cur = p_reg.ir_sh;
        bstc_pkg::ST_UPD_DR:
        begin
          if (sel == bstc_pkg::SEL_BND)
          begin
            n_next.bnd_upd = p_reg.bnd_sh;
          end
          if (sel == bstc_pkg::SEL_CTL)
          begin
            n_next.ctl_upd = p_reg.ctl_sh;
          end
        end
        default:
          n_next.ir_cur = n_reg.ir_cur;
      endcase
    end
  end

  always_ff @(negedge TCK_IN)
  begin
    n_reg <= n_next;
  end

  // Core clock domain, level crossings
  always_comb
  begin
    c_next = c_reg;
    if (RST_IN)
    begin
      c_next = '0;
    end
    else if (CE_IN)
    begin
      c_next.run_s1 = p_reg.run_lvl;
      c_next.run_s2 = c_reg.run_s1;
      c_next.mode_s1 = p_reg.mode_lvl;
      c_next.mode_s2 = c_reg.mode_s1;
    end
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    c_reg <= c_next;
  end

  assign TDO_OUT            = n_reg.tdo;
  assign TDO_OE_OUT         = n_reg.tdo_oe;
  assign BOUNDARY_DRIVE_OUT = n_reg.bnd_upd;
  assign CONTROL_CHAIN_OUT  = n_reg.ctl_upd;
  assign TEST_MODE_OUT      = c_reg.mode_s2;
  assign RUN_TEST_OUT       = c_reg.run_s2;

  AST_TMS_RESET:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      (TMS_IN && ce_t)[*5] |=> p_reg.state == bstc_pkg::ST_TLR)
    else $error("Mode select high did not reach reset state");
  AST_UNSTABLE_ONE:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && !(p_reg.state inside {bstc_pkg::ST_TLR, bstc_pkg::ST_RTI,
      bstc_pkg::ST_SH_DR, bstc_pkg::ST_PAU_DR, bstc_pkg::ST_SH_IR,
      bstc_pkg::ST_PAU_IR}) |=> p_reg.state != $past(p_reg.state))
    else $error("Unstable state held");
  AST_SELECT_DR:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state == bstc_pkg::ST_SEL_DR |=>
      p_reg.state == ($past(TMS_IN) ? bstc_pkg::ST_SEL_IR : bstc_pkg::ST_CAP_DR))
    else $error("Bad exit from select state");
  AST_IR_CAPTURE:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state == bstc_pkg::ST_CAP_IR |=> p_reg.ir_sh == 8'h81)
    else $error("Instruction capture value wrong");
  AST_IR_SHIFT:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state == bstc_pkg::ST_SH_IR |=>
      p_reg.ir_sh == {$past(TDI_IN), $past(p_reg.ir_sh[7:1])})
    else $error("Instruction shift wrong");
  AST_PAUSE_HOLD:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      p_reg.state == bstc_pkg::ST_PAU_IR ##1 p_reg.state == bstc_pkg::ST_PAU_IR
      |-> $stable(p_reg.ir_sh))
    else $error("Pause altered instruction chain");
  AST_TDO_DRIVE:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state == bstc_pkg::ST_SH_IR |-> TDO_OE_OUT && TDO_OUT == p_reg.ir_sh[0])
    else $error("TDO not driving instruction lsb");
  AST_TDO_RELEASE:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state inside {bstc_pkg::ST_EX1_DR, bstc_pkg::ST_EX1_IR} |-> !TDO_OE_OUT)
    else $error("TDO still driven in exit state");
  AST_IR_UPDATE:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state == bstc_pkg::ST_UPD_IR ##1 1'b1 |-> n_reg.ir_cur == $past(p_reg.ir_sh))
    else $error("Instruction not updated");
  AST_IR_RESET:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state == bstc_pkg::ST_TLR ##1 1'b1 |-> n_reg.ir_cur == 8'h81)
    else $error("Instruction not reset to identification");
  AST_RESET_NO_MODE:
    assert property (@(posedge TCK_IN) disable iff (rst_t)
      ce_t && p_reg.state == bstc_pkg::ST_TLR |-> !p_reg.mode_lvl)
    else $error("Test mode active in reset state");

  COV_DR_SCAN: cover property (@(posedge TCK_IN) disable iff (rst_t)
    p_reg.state == bstc_pkg::ST_SH_DR ##1 p_reg.state == bstc_pkg::ST_EX1_DR);
  COV_IR_PAUSE: cover property (@(posedge TCK_IN) disable iff (rst_t)
    p_reg.state == bstc_pkg::ST_PAU_IR ##1 p_reg.state == bstc_pkg::ST_EX2_IR
    ##1 p_reg.state == bstc_pkg::ST_SH_IR);
  COV_IR_UPDATE: cover property (@(posedge TCK_IN) disable iff (rst_t)
    p_reg.state == bstc_pkg::ST_UPD_IR);
  COV_RUN_TEST: cover property (@(posedge CORE_CLK_IN) disable iff (RST_IN) RUN_TEST_OUT);
endmodule
`default_nettype wire

// File: test/bstc_tester.sv
`timescale 1ns/1ps
`default_nettype none
module bstc_tester (
  output var  logic tck_out,
  output var  logic tms_out,
  output var  logic tdi_out,
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  // Test clock stands low outside frames
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  task automatic cyc(input logic tms, input logic tdi, output logic tdo, output logic oe);
    tms_out = tms;
    tdi_out = tdi;
    #3;
    tdo     = tdo_in;
    oe      = tdo_oe_in;
    tck_out = 1'b1;
    #3;
    tck_out = 1'b0;
  endtask

  task automatic walk(input logic [7:0] seq, input int n);
    logic t;
    logic o;
    for (int i = 0; i < n; i++)
      cyc(seq[i], 1'b1, t, o);
  endtask

  task automatic scan(input int n, input logic [95:0] din, input logic last,
                      output logic [95:0] dout, output logic oe_ok);
    logic t;
    logic o;
    dout  = '0;
    oe_ok = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      cyc(last && (i == n - 1), din[i], t, o);
      dout[i] = t;
      oe_ok   = oe_ok & o;
    end
    // Pull-up level once released
    tdi_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam time DLY = 1ns;
  localparam int LIMIT = 20000;
  // Arbitrary identification value
  localparam logic [31:0] ID_VAL = 32'h1357_9bdf;
  localparam logic [87:0] PINS = 88'h5a_1234_5678_9abc_def0_1357;
  localparam logic [95:0] PAT = 96'hc3a5_9617_e24d_0b8f_7165_d29e;

  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  len;
    logic [87:0] cap;
    logic [1:0]  upd;
    logic        mode;
    logic        run;
  } bstc_row_t;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdo_oe;
  logic        test_mode;
  logic        run_test;
  logic [87:0] bnd;
  logic [22:0] ctl;
  logic [95:0] o;
  logic [95:0] o2;
  logic        ok;
  logic        t;
  int          failures = 0;
  int          check_count = 0;
  int          cycles = 0;

  // Opcode, length, capture, shadow kind, test mode, run status
  bstc_row_t rows [6] = '{
    '{8'h81, 8'd32, 88'(ID_VAL), 2'd0, 1'b0, 1'b0},
    '{8'h01, 8'd1,  88'h0,       2'd0, 1'b0, 1'b0},
    '{8'h09, 8'd23, 88'h0,       2'd2, 1'b0, 1'b1},
    '{8'h00, 8'd88, PINS,        2'd1, 1'b1, 1'b0},
    '{8'h82, 8'd88, PINS,        2'd0, 1'b0, 1'b0},
    '{8'h03, 8'd1,  88'h0,       2'd0, 1'b0, 1'b0}
  };

  always #2 core_clk = ~core_clk;

  bstc_top #(.IDCODE_VAL(ID_VAL)) i_bstc_top (
    .CORE_CLK_IN        (core_clk),
    .RST_IN             (rst),
    .CE_IN              (ce),
    .TCK_IN             (tck),
    .TMS_IN             (tms),
    .TDI_IN             (tdi),
    .BOUNDARY_SAMPLE_IN (PINS),
    .TDO_OUT            (tdo),
    .TDO_OE_OUT         (tdo_oe),
    .BOUNDARY_DRIVE_OUT (bnd),
    .CONTROL_CHAIN_OUT  (ctl),
    .TEST_MODE_OUT      (test_mode),
    .RUN_TEST_OUT       (run_test)
  );

  bstc_tester i_bstc_tester (
    .tck_out   (tck),
    .tms_out   (tms),
    .tdi_out   (tdi),
    .tdo_in    (tdo),
    .tdo_oe_in (tdo_oe)
  );

  task automatic summarize();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk_vec(input string name, input logic [95:0] e, input logic [95:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_bit(input string name, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic settle();
    repeat (4) @(posedge core_clk);
    #DLY;
  endtask

  task automatic run_row(input bstc_row_t r);
    logic [95:0] mask;
    mask = (96'h1 << r.len) - 96'h1;
    i_bstc_tester.walk(8'h03, 4);
    i_bstc_tester.scan(8, 96'(r.op), 1'b1, o, ok);
    chk_vec("ir_capture", 96'(bstc_pkg::IR_CAPTURE), o);
    i_bstc_tester.walk(8'h01, 5);
    settle();
    chk_bit("test_mode", r.mode, test_mode);
    chk_bit("run_test", r.run, run_test);
    i_bstc_tester.walk(8'h01, 3);
    i_bstc_tester.scan(int'(r.len) + 8, PAT, 1'b1, o, ok);
    chk_vec("dr_capture", 96'(r.cap) & mask, o & mask);
    chk_vec("dr_length", PAT & 96'hff, (o >> r.len) & 96'hff);
    chk_bit("tdo_oe_shift", 1'b1, ok);
    i_bstc_tester.walk(8'h01, 2);
    if (r.upd == 2'd1)
      chk_vec("boundary_drive", 96'(PAT[95:8]), 96'(bnd));
    if (r.upd == 2'd2)
      chk_vec("control_chain", 96'(PAT[30:8]), 96'(ctl));
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      failures++;
      summarize();
    end
  end

  initial
  begin
    fork
      repeat (5) @(posedge core_clk);
      i_bstc_tester.walk(8'hff, 4);
    join
    @(posedge core_clk);
    #DLY;
    rst = 1'b0;
    i_bstc_tester.walk(8'h1f, 6);
    settle();
    chk_bit("tdo_oe_reset", 1'b0, tdo_oe);
    chk_bit("test_mode_reset", 1'b0, test_mode);
    chk_vec("boundary_reset", 96'(bstc_pkg::BND_RESET), 96'(bnd));
    chk_vec("control_reset", 96'(bstc_pkg::CTL_RESET), 96'(ctl));
    i_bstc_tester.walk(8'h01, 3);
    i_bstc_tester.scan(40, PAT, 1'b1, o, ok);
    chk_vec("reset_instr", 96'(ID_VAL), o & 96'hffff_ffff);
    i_bstc_tester.walk(8'h01, 2);
    foreach (rows[i])
      run_row(rows[i]);
    // Pause in mid scan, resume without recapture
    run_row(rows[0]);
    i_bstc_tester.walk(8'h01, 3);
    i_bstc_tester.scan(16, PAT, 1'b1, o, ok);
    i_bstc_tester.cyc(1'b0, 1'b1, t, ok);
    chk_bit("tdo_oe_exit1", 1'b0, ok);
    i_bstc_tester.walk(8'h00, 3);
    i_bstc_tester.walk(8'h01, 2);
    i_bstc_tester.scan(16, PAT, 1'b1, o2, ok);
    chk_vec("resume", 96'(ID_VAL[31:16]), o2 & 96'hffff);
    i_bstc_tester.walk(8'h01, 2);
    // Escape from shift state with mode select held high
    run_row(rows[3]);
    // Clock enable low freezes the access port in idle
    @(posedge core_clk);
    #DLY;
    ce = 1'b0;
    i_bstc_tester.walk(8'h00, 3);
    i_bstc_tester.walk(8'h1f, 5);
    @(posedge core_clk);
    #DLY;
    ce = 1'b1;
    i_bstc_tester.walk(8'h00, 3);
    settle();
    chk_bit("ce_freeze", 1'b1, test_mode);
    i_bstc_tester.walk(8'h01, 3);
    i_bstc_tester.walk(8'h1f, 5);
    settle();
    chk_bit("test_mode_escape", 1'b0, test_mode);
    chk_vec("boundary_escape", 96'(bstc_pkg::BND_RESET), 96'(bnd));
    summarize();
  end
endmodule
`default_nettype wire
